// ### hdl/qds_serial_dac.sv
// Operation
// - A 24-bit shift register captures one command word per frame.
// - Words shift in most significant bit first, one bit per serial clock.
// - Word splits into read flag, register selector, channel address, 16 data bits.
// - Every channel's DAC register resets to code zero.
// - Channel outputs stay clamped to ground until powered up by command.
// - Bipolar midscale is 0x8000 offset binary, 0x0000 twos complement.
// - Zero scale is 0x0000 straight binary, 0x8000 twos complement.
// - Serial data output passes shifted words onward or returns register contents.
// - Frame starts on select fall; register updates on select rise after 24 edges.
// - Frames with fewer or more than 24 falling clock edges are discarded.
// - Serial data output changes on rising serial clock edge.
// - A read word makes the next frame shift out the selected register.
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
`default_nettype none
module qds_serial_dac
    import qds_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clock,
    input wire logic frame_select_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic [CHANNELS-1:0][DATA_BITS-1:0] channel_code,
    output logic [CHANNELS-1:0] channel_clamp
);
    logic [2:0] pin_lvl;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic sdi_lvl;
    logic sclk_rise;
    logic sclk_fall;
    logic fs_rise;
    logic fs_fall;
    logic active_r;
    logic [4:0] bit_cnt_r;
    logic [WORD_BITS-1:0] shift_r;
    logic rd_pend_r;
    logic [DATA_BITS-1:0] rd_data;
    logic frame_end;
    logic frame_ok;
    qds_cmd_type cmd;
    logic [CHANNELS-1:0][DATA_BITS-1:0] dac_r;
    logic [CHANNELS-1:0] power_r;
    logic [31:0] ctrl_r;
    logic [7:0] ok_cnt_r;
    logic [7:0] bad_cnt_r;
    logic [31:0] rd_mux;
    logic map_hit;
    logic wr_dac;

    // ----------------------------------------------------------------
    // Pin synchronisers: bit2 clock, bit1 frame select, bit0 data
    // ----------------------------------------------------------------
    qds_pin_sync #(.W(3), .IDLE(3'h6)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({serial_clock, frame_select_n, serial_data_in}),
        .level(pin_lvl),
        .rise(pin_rise),
        .fall(pin_fall)
    );

    assign sdi_lvl = pin_lvl[0];
    assign sclk_rise = pin_rise[2];
    assign sclk_fall = pin_fall[2];
    assign fs_rise = pin_rise[1];
    assign fs_fall = pin_fall[1];
    assign cmd = qds_cmd_type'(shift_r);
    assign frame_end = fs_rise && active_r;
    assign frame_ok = frame_end && (bit_cnt_r == WORD_COUNT);
    assign wr_dac = frame_ok && !cmd.read_flag && (cmd.register_selector == SEL_DAC);

    // ----------------------------------------------------------------
    // Frame engine and shift register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_r <= 1'b0;
            bit_cnt_r <= 5'h00;
            shift_r <= '0;
            serial_data_out <= 1'b0;
            rd_pend_r <= 1'b0;
        end else if (fs_fall) begin
            active_r <= 1'b1;
            bit_cnt_r <= 5'h00;
            if (rd_pend_r) begin
                shift_r <= {READ_PAD, rd_data};
                serial_data_out <= READ_PAD[7];
            end else begin
                serial_data_out <= shift_r[WORD_BITS-1];
            end
            rd_pend_r <= 1'b0;
        end else if (frame_end) begin
            active_r <= 1'b0;
            rd_pend_r <= frame_ok && cmd.read_flag;
        end else if (active_r && sclk_fall) begin
            shift_r <= {shift_r[WORD_BITS-2:0], sdi_lvl};
            if (bit_cnt_r != COUNT_CEIL) begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end else if (active_r && sclk_rise) begin
            serial_data_out <= shift_r[WORD_BITS-1];
        end
    end

    // ----------------------------------------------------------------
    // Readback source, latched at end of the read word
    // ----------------------------------------------------------------
    logic [2:0] rd_sel_r;
    logic [2:0] rd_ch_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_sel_r <= SEL_DAC;
            rd_ch_r <= 3'h0;
        end else if (frame_ok && cmd.read_flag) begin
            rd_sel_r <= cmd.register_selector;
            rd_ch_r <= cmd.channel_address;
        end
    end

    always_comb begin
        rd_data = '0;
        if (rd_sel_r == SEL_DAC && rd_ch_r < CH_ALL) begin
            rd_data = dac_r[rd_ch_r[1:0]];
        end else if (rd_sel_r == SEL_POWER) begin
            rd_data = {12'h000, power_r};
        end
    end

    // ----------------------------------------------------------------
    // DAC and power registers, updated on valid frame end
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dac_r <= {CHANNELS{DAC_RESET}};
        end else if (wr_dac) begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (cmd.channel_address == CH_ALL || cmd.channel_address == 3'(i)) begin
                    dac_r[i] <= cmd.data;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            power_r <= POWER_RESET;
        end else if (frame_ok && !cmd.read_flag && cmd.register_selector == SEL_POWER) begin
            power_r <= cmd.data[CHANNELS-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Channel output codes in offset-binary form
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            channel_code <= {CHANNELS{CODE_ZEROSCALE}};
            channel_clamp <= {CHANNELS{1'b1}};
        end else begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (ctrl_r[CTRL_TWOS_BIT]) begin
                    channel_code[i] <= dac_r[i] ^ CODE_MIDSCALE;
                end else begin
                    channel_code[i] <= dac_r[i];
                end
                channel_clamp[i] <= !power_r[i];
            end
        end
    end

    // ----------------------------------------------------------------
    // Frame statistics
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ok_cnt_r <= 8'h00;
            bad_cnt_r <= 8'h00;
        end else if (frame_ok) begin
            ok_cnt_r <= ok_cnt_r + 8'h01;
        end else if (frame_end) begin
            bad_cnt_r <= bad_cnt_r + 8'h01;
        end
    end

    // ----------------------------------------------------------------
    // APB slave: answer in the first access cycle
    // ----------------------------------------------------------------
    always_comb begin
        rd_mux = 32'h0000_0000;
        map_hit = 1'b1;
        case (paddr)
            OFS_CTRL: rd_mux = ctrl_r;
            OFS_STATUS: rd_mux = {14'h0000, rd_pend_r, active_r, bad_cnt_r, ok_cnt_r};
            OFS_POWER: rd_mux = {28'h0000000, power_r};
            OFS_CODE0: rd_mux = {16'h0000, dac_r[0]};
            OFS_CODE0 + 12'h004: rd_mux = {16'h0000, dac_r[1]};
            OFS_CODE0 + 12'h008: rd_mux = {16'h0000, dac_r[2]};
            OFS_CODE0 + 12'h00C: rd_mux = {16'h0000, dac_r[3]};
            default: map_hit = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !map_hit;
            prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RESET;
        end else if (psel && penable && pready && pwrite && paddr == OFS_CTRL) begin
            ctrl_r <= {31'h00000000, pwdata[CTRL_TWOS_BIT]};
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence frame_done_s;
        frame_end && bit_cnt_r == WORD_COUNT;
    endsequence

    sequence frame_bad_s;
        frame_end && bit_cnt_r != WORD_COUNT;
    endsequence

    shift_msb_a: assert property (@(posedge pclk) disable iff (!presetn)
        active_r && sclk_fall && !fs_fall && !fs_rise |=> shift_r[0] == $past(sdi_lvl)
        && shift_r[WORD_BITS-1:1] == $past(shift_r[WORD_BITS-2:0]))
        else $error("shift register did not take data in msb-first order");
    count_ceiling_a: assert property (@(posedge pclk) disable iff (!presetn)
        bit_cnt_r <= COUNT_CEIL)
        else $error("edge count passed its ceiling");
    bad_frame_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
        frame_bad_s |=> $stable(dac_r) && $stable(power_r) && !rd_pend_r)
        else $error("invalid frame changed state");
    dac_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        frame_done_s ##0 (!cmd.read_flag && cmd.register_selector == SEL_DAC
        && cmd.channel_address == 3'h1) |=> dac_r[1] == $past(cmd.data))
        else $error("valid frame did not update channel register");
    clamp_power_a: assert property (@(posedge pclk) disable iff (!presetn)
        !power_r[0] [*2] |-> channel_clamp[0])
        else $error("unpowered channel not clamped");
    midscale_a: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_r[CTRL_TWOS_BIT] && dac_r[1] == 16'h0000 |=> channel_code[1] == CODE_MIDSCALE)
        else $error("twos complement zero not midscale");
    zero_scale_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_r[CTRL_TWOS_BIT] && dac_r[1] == 16'h0000 |=> channel_code[1] == CODE_ZEROSCALE)
        else $error("straight binary zero not zero scale");
    sdo_edge_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(serial_data_out) |-> $past(sclk_rise) || $past(fs_fall))
        else $error("serial data output changed off a rising clock edge");
    readback_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        fs_fall && rd_pend_r |=> shift_r == {READ_PAD, $past(rd_data)} && !rd_pend_r)
        else $error("readback word not loaded at frame start");
endmodule : qds_serial_dac
`default_nettype wire

// ### hdl/qds_pkg.sv
package qds_pkg;

    // ----------------------------------------------------------------
    // Serial word layout
    // ----------------------------------------------------------------
    localparam int WORD_BITS = 24;
    localparam int DATA_BITS = 16;
    localparam int CHANNELS = 4;
    localparam logic [4:0] WORD_COUNT = 5'h18;
    localparam logic [4:0] COUNT_CEIL = 5'h19;

    typedef struct packed {
        logic read_flag;
        logic spare;
        logic [2:0] register_selector;
        logic [2:0] channel_address;
        logic [15:0] data;
    } qds_cmd_type;

    // ----------------------------------------------------------------
    // Register selector and channel codes
    // ----------------------------------------------------------------
    localparam logic [2:0] SEL_DAC = 3'h0;
    localparam logic [2:0] SEL_POWER = 3'h2;
    localparam logic [2:0] CH_ALL = 3'h4;

    // ----------------------------------------------------------------
    // Reset values and code conventions
    // ----------------------------------------------------------------
    localparam logic [15:0] DAC_RESET = 16'h0000;
    localparam logic [3:0] POWER_RESET = 4'h0;
    localparam logic [15:0] CODE_MIDSCALE = 16'h8000;
    localparam logic [15:0] CODE_ZEROSCALE = 16'h0000;
    localparam logic [7:0] READ_PAD = 8'h00;

    // ----------------------------------------------------------------
    // Host clock limit, for reference by the bench
    // ----------------------------------------------------------------
    localparam int SCLK_MAX_MHZ = 30;
    localparam int PCLK_MHZ = 50;

    // ----------------------------------------------------------------
    // APB map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [11:0] OFS_CTRL = 12'h000;
    localparam logic [11:0] OFS_STATUS = 12'h004;
    localparam logic [11:0] OFS_POWER = 12'h008;
    localparam logic [11:0] OFS_CODE0 = 12'h010;
    localparam int CTRL_TWOS_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

endpackage : qds_pkg

// ### hdl/qds_pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module qds_pin_sync #(
    parameter int W = 3,
    parameter logic [W-1:0] IDLE = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level,
    output logic [W-1:0] rise,
    output logic [W-1:0] fall
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // ----------------------------------------------------------------
    // Three stages; a change counts once stages two and three agree
    // ----------------------------------------------------------------
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                s1_r[i] <= IDLE[i];
                s2_r[i] <= IDLE[i];
                s3_r[i] <= IDLE[i];
                level[i] <= IDLE[i];
                rise[i] <= 1'b0;
                fall[i] <= 1'b0;
            end else begin
                s1_r[i] <= pin_in[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                rise[i] <= (s2_r[i] == s3_r[i]) && s3_r[i] && !level[i];
                fall[i] <= (s2_r[i] == s3_r[i]) && !s3_r[i] && level[i];
                if (s2_r[i] == s3_r[i]) begin
                    level[i] <= s3_r[i];
                end
            end
        end
    end
endmodule : qds_pin_sync
`default_nettype wire

// ### verification/qds_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module qds_host_model
    import qds_pkg::*;
#(
    parameter int HALF = 8
) (
    input wire logic pclk,
    output logic serial_clock,
    output logic frame_select_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    logic [23:0] rx_word;

    initial begin
        serial_clock = 1'b1;
        frame_select_n = 1'b1;
        serial_data_in = 1'b0;
        rx_word = '0;
    end

    // Clock stands high between frames; clocks past a word carry zeros
    task automatic send_frame(input logic [23:0] word, input int nbits);
        @(posedge pclk);
        frame_select_n <= 1'b0;
        repeat (8) @(posedge pclk);
        for (int i = 0; i < nbits; i++) begin
            serial_data_in <= (i < WORD_BITS) ? word[WORD_BITS-1-i] : 1'b0;
            // Each level lasts past the pin sync latency so output bits settle first
            repeat (HALF) @(posedge pclk);
            rx_word <= {rx_word[22:0], serial_data_out};
            serial_clock <= 1'b0;
            repeat (HALF) @(posedge pclk);
            serial_clock <= 1'b1;
        end
        repeat (HALF) @(posedge pclk);
        frame_select_n <= 1'b1;
        serial_data_in <= ~serial_data_in;
        repeat (12) @(posedge pclk);
    endtask : send_frame
endmodule : qds_host_model
`default_nettype wire

// ### verification/quad_dac_serial_input_frame_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_input_frame_tb_top
    import qds_pkg::*;
;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic serial_clock;
    logic frame_select_n;
    logic serial_data_in;
    logic serial_data_out;
    logic [CHANNELS-1:0][DATA_BITS-1:0] channel_code;
    logic [CHANNELS-1:0] channel_clamp;
    int fails = 0;
    int checks_done = 0;
    logic [7:0] exp_good = 8'h00;
    logic [7:0] exp_bad = 8'h00;
    logic [31:0] rd;
    logic err;

    qds_serial_dac u_qds_serial_dac (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_clock(serial_clock),
        .frame_select_n(frame_select_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .channel_code(channel_code),
        .channel_clamp(channel_clamp));

    qds_host_model u_qds_host_model (.pclk(pclk), .serial_clock(serial_clock),
        .frame_select_n(frame_select_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out));

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wdata);
        int n;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= wdata;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            fails++;
            $display("Error at %0t: no bus answer", $time);
            give_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd_check(input logic [11:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(rd, exp);
    endtask : rd_check

    function automatic logic [23:0] cmd(input logic r, input logic [2:0] s,
            input logic [2:0] c, input logic [15:0] d);
        qds_cmd_type w;
        w = '{r, 1'b0, s, c, d};
        return w;
    endfunction : cmd

    task automatic send(input logic [23:0] w, input int nbits);
        if (nbits == WORD_BITS) exp_good++;
        else exp_bad++;
        u_qds_host_model.send_frame(w, nbits);
    endtask : send

    task automatic codes_check(input logic [15:0] exp);
        for (int i = 0; i < CHANNELS; i++) check({16'h0000, channel_code[i]}, {16'h0000, exp});
    endtask : codes_check

    initial begin
        repeat (100000) @(posedge pclk);
        fails++;
        $display("Error at %0t: run timed out", $time);
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        codes_check(DAC_RESET);
        check({28'h0, channel_clamp}, 32'h0000_000F);
        rd_check(OFS_CTRL, CTRL_RESET);
        rd_check(OFS_STATUS, 32'h0000_0000);
        rd_check(OFS_POWER, {28'h0, POWER_RESET});
        for (int i = 0; i < CHANNELS; i++) rd_check(OFS_CODE0 + 12'(4 * i), 32'h0);
        apb(1'b1, 12'h0FC, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h1);
        rd_check(12'h0FC, 32'h0);
        check({31'h0, err}, 32'h1);
        $display("test reset done");
        send(cmd(1'b0, SEL_POWER, 3'h0, 16'h000F), 24);
        check({28'h0, channel_clamp}, 32'h0);
        rd_check(OFS_POWER, 32'h0000_000F);
        apb(1'b1, OFS_POWER, 32'h0);
        rd_check(OFS_POWER, 32'h0000_000F);
        send(cmd(1'b0, SEL_DAC, 3'h1, 16'h1234), 24);
        check({16'h0, channel_code[1]}, 32'h1234);
        rd_check(OFS_CODE0 + 12'h004, 32'h1234);
        $display("test write done");
        send(cmd(1'b1, SEL_DAC, 3'h1, 16'h0000), 24);
        rd_check(OFS_STATUS, {14'h0, 1'b1, 1'b0, exp_bad, exp_good});
        send(cmd(1'b0, SEL_DAC, 3'h3, 16'h5A5A), 24);
        check({8'h0, u_qds_host_model.rx_word}, {8'h0, READ_PAD, 16'h1234});
        check({16'h0, u_qds_host_model.rx_word[15:0]}, 32'h1234);
        check({16'h0, channel_code[3]}, 32'h5A5A);
        send(24'h180000, 24);
        check({8'h0, u_qds_host_model.rx_word}, {8'h0, cmd(1'b0, SEL_DAC, 3'h3, 16'h5A5A)});
        $display("test readback done");
        send(cmd(1'b0, SEL_DAC, 3'h2, 16'hFFFF), 23);
        send(cmd(1'b0, SEL_DAC, 3'h2, 16'hFFFF), 25);
        check({16'h0, channel_code[2]}, 32'h0);
        rd_check(OFS_STATUS, {16'h0, exp_bad, exp_good});
        $display("test bad frames done");
        send(cmd(1'b0, SEL_DAC, CH_ALL, CODE_ZEROSCALE), 24);
        codes_check(CODE_ZEROSCALE);
        apb(1'b1, OFS_CTRL, 32'h0000_0001);
        repeat (3) @(posedge pclk);
        codes_check(CODE_MIDSCALE);
        send(cmd(1'b0, SEL_DAC, CH_ALL, 16'h8000), 24);
        codes_check(CODE_ZEROSCALE);
        apb(1'b1, OFS_CTRL, 32'h0000_0000);
        repeat (3) @(posedge pclk);
        codes_check(CODE_MIDSCALE);
        rd_check(OFS_CTRL, 32'h0);
        $display("test coding done");
        give_verdict();
    end
endmodule : quad_dac_serial_input_frame_tb_top
`default_nettype wire
